// ---- core/edge_sync.sv ----
// synchroniser and edge detector for an input pin
module edge_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic stable;

   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= 1'b0;
         stable <= 1'b0;
         level <= 1'b0;
      end else begin
         meta <= pin;
         stable <= meta;
         level <= stable;
      end
   end

   always_comb begin
      rise = stable & ~level;
      fall = ~stable & level;
   end
endmodule

// ---- core/periodic_timer.sv ----
// periodic timer: compare, pwm, single pulse and capture modes
module periodic_timer (
   input wire logic clk,
   input wire logic reset,
   input wire periodic_timer_pkg::reg_req_t req,
   output logic [7:0] rdata,
   input wire logic ext_clock_pin,
   input wire logic capture_input_pin,
   output logic timer_out,
   output logic compare_a_flag,
   output logic period_match_flag,
   output logic irq_pulse
);
   periodic_timer_pkg::timer_control_1_t ctrl;
   logic run_bit;
   logic [9:0] count;
   logic [9:0] compare_a_value;
   logic [9:0] period_value;
   logic raw_out;
   logic run_prev;
   periodic_timer_pkg::phase_t phase;
   logic ck_rise;
   logic ck_fall;
   logic cp_rise;
   logic cp_fall;

   edge_sync u_ck (
      .clk(clk),
      .reset(reset),
      .pin(ext_clock_pin),
      .level(),
      .rise(ck_rise),
      .fall(ck_fall)
   );

   edge_sync u_cp (
      .clk(clk),
      .reset(reset),
      .pin(capture_input_pin),
      .level(),
      .rise(cp_rise),
      .fall(cp_fall)
   );

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic r, input logic f);
      case (sel)
         periodic_timer_pkg::EDGE_RISE: edge_hit = r;
         periodic_timer_pkg::EDGE_FALL: edge_hit = f;
         periodic_timer_pkg::EDGE_BOTH: edge_hit = r | f;
         default: edge_hit = 1'b0;
      endcase
   endfunction

   function automatic logic [9:0] load_lo(input logic [9:0] v,
                                          input logic [7:0] d);
      load_lo = {v[9:8], d};
   endfunction

   function automatic logic [9:0] load_hi(input logic [9:0] v,
                                          input logic [7:0] d);
      load_hi = {d[1:0], v[7:0]};
   endfunction

   function automatic logic bus_write(input periodic_timer_pkg::reg_req_t r,
                                      input logic [3:0] a);
      bus_write = r.wr && r.addr == a;
   endfunction

   function automatic logic [7:0] hi_byte(input logic [9:0] v);
      hi_byte = {6'h00, v[9:8]};
   endfunction

   // decode
   logic wr_ctrl0;
   logic wr_ctrl1;
   logic wr_flags;
   logic wr_cmpa_lo;
   logic wr_cmpa_hi;
   logic wr_per_lo;
   logic wr_per_hi;
   logic is_capture;
   logic is_pulse;
   logic is_pwm;
   logic no_output;
   logic run_rise;
   logic match_a;
   logic match_p;
   logic per_zero;
   logic sel_rise;
   logic sel_fall;
   logic capture_hit;
   logic pulse_trigger;
   logic a_event;
   logic p_event;
   logic clear_count;
   logic next_run;

   // register write strobes
   always_comb begin
      wr_ctrl0 = bus_write(req, periodic_timer_pkg::ADDR_CTRL0);
      wr_ctrl1 = bus_write(req, periodic_timer_pkg::ADDR_CTRL1);
      wr_flags = bus_write(req, periodic_timer_pkg::ADDR_FLAGS);
      wr_cmpa_lo = bus_write(req, periodic_timer_pkg::ADDR_CMPA_LO);
      wr_cmpa_hi = bus_write(req, periodic_timer_pkg::ADDR_CMPA_HI);
      wr_per_lo = bus_write(req, periodic_timer_pkg::ADDR_PER_LO);
      wr_per_hi = bus_write(req, periodic_timer_pkg::ADDR_PER_HI);
   end

   // mode decode
   always_comb begin
      is_capture = ctrl.mode == periodic_timer_pkg::MODE_CAPTURE;
      is_pulse = ctrl.mode == periodic_timer_pkg::MODE_PWM
         && ctrl.pin_action_field == periodic_timer_pkg::ACT_TOGGLE;
      is_pwm = ctrl.mode == periodic_timer_pkg::MODE_PWM && !is_pulse;
      no_output = is_capture
         || ctrl.mode == periodic_timer_pkg::MODE_TIMER;
   end

   // comparators and capture trigger
   always_comb begin
      run_rise = run_bit && !run_prev;
      per_zero = period_value == periodic_timer_pkg::VALUE_RESET;
      match_a = run_bit && count == compare_a_value;
      // zero period means full range: match at top count
      match_p = run_bit && (per_zero ? count == periodic_timer_pkg::COUNT_MAX
                            : count == period_value);
      // selected capture source
      sel_rise = ctrl.capture_source_select ? ck_rise : cp_rise;
      sel_fall = ctrl.capture_source_select ? ck_fall : cp_fall;
      // pin level is watched whatever its direction
      capture_hit = is_capture && run_bit
         && edge_hit(ctrl.pin_action_field, sel_rise, sel_fall);
      pulse_trigger = is_pulse && ck_rise;
   end

   // flag events and counter clear
   always_comb begin
      if (is_capture) begin
         a_event = capture_hit;
         p_event = match_p;
      end else if (is_pulse) begin
         a_event = match_a && phase == periodic_timer_pkg::PHASE_RUN;
         p_event = 1'b0;
      end else if (is_pwm) begin
         a_event = match_a;
         p_event = match_p;
      end else begin
         a_event = match_a;
         p_event = match_p && !ctrl.clear_source_select;
      end
      if (is_capture || is_pwm) begin
         clear_count = match_p;
      end else if (is_pulse) begin
         clear_count = 1'b0;
      end else begin
         clear_count = ctrl.clear_source_select ? match_a : match_p;
      end
   end

   // run bit next value
   always_comb begin
      next_run = run_bit;
      if (wr_ctrl0) begin
         next_run = req.wdata[periodic_timer_pkg::RUN_BIT_POS];
      end
      if (pulse_trigger) begin
         next_run = 1'b1;
      end
      if (a_event && is_pulse) begin
         next_run = 1'b0;
      end
   end

   // control registers
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= periodic_timer_pkg::CTRL1_RESET;
         run_bit <= 1'b0;
         run_prev <= 1'b0;
      end else begin
         if (wr_ctrl1) begin
            ctrl <= req.wdata;
         end
         run_bit <= next_run;
         run_prev <= run_bit;
      end
   end

   // compare registers, capture loads compare a
   always_ff @(posedge clk) begin
      if (reset) begin
         compare_a_value <= periodic_timer_pkg::VALUE_RESET;
         period_value <= periodic_timer_pkg::VALUE_RESET;
      end else begin
         if (capture_hit) begin
            compare_a_value <= count;
         end else if (wr_cmpa_lo) begin
            compare_a_value <= load_lo(compare_a_value, req.wdata);
         end else if (wr_cmpa_hi) begin
            compare_a_value <= load_hi(compare_a_value, req.wdata);
         end
         if (wr_per_lo) begin
            period_value <= load_lo(period_value, req.wdata);
         end else if (wr_per_hi) begin
            period_value <= load_hi(period_value, req.wdata);
         end
      end
   end

   // pulse phase tracking
   always_ff @(posedge clk) begin
      if (reset) begin
         phase <= periodic_timer_pkg::PHASE_IDLE;
      end else begin
         case (phase)
            periodic_timer_pkg::PHASE_IDLE: begin
               if (run_rise) begin
                  phase <= periodic_timer_pkg::PHASE_RUN;
               end
            end
            periodic_timer_pkg::PHASE_RUN: begin
               if (!run_bit) begin
                  phase <= periodic_timer_pkg::PHASE_IDLE;
               end else if (is_pulse && match_a) begin
                  phase <= periodic_timer_pkg::PHASE_HELD;
               end
            end
            periodic_timer_pkg::PHASE_HELD: begin
               if (!run_bit) begin
                  phase <= periodic_timer_pkg::PHASE_IDLE;
               end
            end
            default: phase <= periodic_timer_pkg::PHASE_IDLE;
         endcase
      end
   end

   // counter
   always_ff @(posedge clk) begin
      if (reset) begin
         count <= periodic_timer_pkg::VALUE_RESET;
      end else if (run_rise) begin
         count <= periodic_timer_pkg::VALUE_RESET;
      end else if (run_bit && !(is_pulse && a_event)) begin
         // free runs in capture mode whatever the pin does
         if (clear_count) begin
            count <= periodic_timer_pkg::VALUE_RESET;
         end else begin
            count <= count + 10'h001;
         end
      end
   end

   // flags: set wins over write-one clear
   always_ff @(posedge clk) begin
      if (reset) begin
         compare_a_flag <= 1'b0;
         period_match_flag <= 1'b0;
         irq_pulse <= 1'b0;
      end else begin
         if (a_event) begin
            compare_a_flag <= 1'b1;
         end else if (wr_flags
                      && req.wdata[periodic_timer_pkg::FLAG_A_POS]) begin
            compare_a_flag <= 1'b0;
         end
         if (p_event) begin
            period_match_flag <= 1'b1;
         end else if (wr_flags
                      && req.wdata[periodic_timer_pkg::FLAG_P_POS]) begin
            period_match_flag <= 1'b0;
         end
         irq_pulse <= a_event || p_event;
      end
   end

   // output waveform
   always_ff @(posedge clk) begin
      if (reset) begin
         raw_out <= 1'b0;
      end else if (no_output) begin
         raw_out <= 1'b0;
      end else if (is_pulse) begin
         // leading edge on run rise, trailing on run clear or match
         raw_out <= next_run
            && !(phase == periodic_timer_pkg::PHASE_HELD);
      end else if (is_pwm) begin
         // duty generated always; pin action only gates the pin
         raw_out <= count < compare_a_value;
      end else if (run_rise) begin
         raw_out <= ctrl.output_initial_level;
      end else if (a_event) begin
         case (ctrl.pin_action_field)
            periodic_timer_pkg::ACT_LOW: raw_out <= 1'b0;
            periodic_timer_pkg::ACT_HIGH: raw_out <= 1'b1;
            periodic_timer_pkg::ACT_TOGGLE: raw_out <= ~raw_out;
            default: raw_out <= raw_out;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         timer_out <= 1'b0;
      end else if (no_output) begin
         timer_out <= 1'b0;
      end else if (is_pwm) begin
         case (ctrl.pin_action_field)
            periodic_timer_pkg::ACT_NONE: timer_out <= ctrl.output_invert;
            periodic_timer_pkg::ACT_LOW: timer_out <= ~ctrl.output_invert;
            default: timer_out <= (raw_out ~^ ctrl.output_initial_level)
               ^ ctrl.output_invert;
         endcase
      end else begin
         timer_out <= raw_out ^ ctrl.output_invert;
      end
   end

   // read data, one cycle after strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            periodic_timer_pkg::ADDR_CTRL0:
               rdata <= {4'h0, run_bit, 3'h0};
            periodic_timer_pkg::ADDR_CTRL1: rdata <= ctrl;
            periodic_timer_pkg::ADDR_CNT_LO: rdata <= count[7:0];
            periodic_timer_pkg::ADDR_CNT_HI: rdata <= hi_byte(count);
            periodic_timer_pkg::ADDR_CMPA_LO: rdata <= compare_a_value[7:0];
            periodic_timer_pkg::ADDR_CMPA_HI:
               rdata <= hi_byte(compare_a_value);
            periodic_timer_pkg::ADDR_PER_LO: rdata <= period_value[7:0];
            periodic_timer_pkg::ADDR_PER_HI:
               rdata <= hi_byte(period_value);
            periodic_timer_pkg::ADDR_FLAGS:
               rdata <= {6'h00, period_match_flag, compare_a_flag};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule

// ---- core/periodic_timer_pkg.sv ----
// package: constants, types and overview of the periodic timer
// Overview of operation
// - pwm keeps counting and comparing even when pin action forces output.
// - pwm period set by period compare clear; clear source select ignored.
// - single pulse mode is mode 10 with pin action 11.
// - run bit rising starts counter and pulse leading edge.
// - ext clock pin active edge sets run bit in single pulse mode.
// - trailing edge on run clear or compare a match; match clears run.
// - single pulse compare a match raises timer interrupt request.
// - single pulse counter zeroed only on run rise; stops after match.
// - single pulse ignores period value and clear source select.
// - capture mode is mode 01.
// - capture source is capture pin or ext clock pin per select.
// - pin action selects rising, falling or both capture edges.
// - capture counter starts on run rise, free runs until run falls.
// - active capture edge copies counter to compare a, raises interrupt.
// - capture period match zeroes counter and raises interrupt.
// - capture period value zero gives full count range.
// - capture pin action 11 disables capture, counter keeps running.
// - capture ignores clear select, initial level, invert; no output.
// - selected pin captures even when configured as an output.
// - counter and compares are 10 bits, split low byte and 2-bit high.
// - capture source select 0 picks capture pin, 1 picks ext clock.
package periodic_timer_pkg;
   localparam int CNT_W = 10;
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL1 = 4'h1;
   localparam logic [3:0] ADDR_CNT_LO = 4'h2;
   localparam logic [3:0] ADDR_CNT_HI = 4'h3;
   localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
   localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
   localparam logic [3:0] ADDR_PER_LO = 4'h6;
   localparam logic [3:0] ADDR_PER_HI = 4'h7;
   localparam logic [3:0] ADDR_FLAGS = 4'h8;
   // control 0 bit positions
   localparam int RUN_BIT_POS = 3;
   // control 1 bit positions
   localparam int MODE_HI_POS = 7;
   localparam int MODE_LO_POS = 6;
   localparam int PIN_ACT_HI_POS = 5;
   localparam int PIN_ACT_LO_POS = 4;
   localparam int INIT_LEVEL_POS = 3;
   localparam int INVERT_POS = 2;
   localparam int CAP_SRC_POS = 1;
   localparam int CLR_SRC_POS = 0;
   // flags register bit positions, write one to clear
   localparam int FLAG_A_POS = 0;
   localparam int FLAG_P_POS = 1;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [9:0] VALUE_RESET = 10'h000;
   localparam logic [9:0] COUNT_MAX = 10'h3FF;
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TIMER = 2'h3;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   localparam logic [1:0] EDGE_NONE = 2'h3;

   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] pin_action_field;
      logic output_initial_level;
      logic output_invert;
      logic capture_source_select;
      logic clear_source_select;
   } timer_control_1_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef enum logic [1:0] {
      PHASE_IDLE,
      PHASE_RUN,
      PHASE_HELD
   } phase_t;
endpackage

// ---- tb/periodic_timer_assertions.sv ----
// port-level checker for the periodic timer
module periodic_timer_assertions (
   input wire logic clk,
   input wire logic reset,
   input wire periodic_timer_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic ext_clock_pin,
   input wire logic capture_input_pin,
   input wire logic timer_out,
   input wire logic compare_a_flag,
   input wire logic period_match_flag,
   input wire logic irq_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl;
   logic sp;
   logic cap;
   logic cap_off;
   // shadow of control 1 taken from bus writes
   always_ff @(posedge clk) begin
      if (reset) begin
         ctl <= 8'h00;
      end else if (req.wr && req.addr == periodic_timer_pkg::ADDR_CTRL1) begin
         ctl <= req.wdata;
      end
   end
   assign sp = ctl[7:4] == 4'hB;
   assign cap = ctl[7:6] == 2'h1;
   assign cap_off = cap && ctl[5:4] == 2'h3;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   hi_bytes_a: assert property (
      $past(req.rd && req.addr[0] && req.addr inside {[4'h3:4'h7]})
      |-> rdata[7:2] == 6'h00) else $error("upper bits not zero");
   ctrl_read_a: assert property (
      $past(req.rd && req.addr == periodic_timer_pkg::ADDR_CTRL1)
      |-> rdata == $past(ctl)) else $error("control 1 readback wrong");
   flag_clear_a: assert property (
      req.wr && req.addr == periodic_timer_pkg::ADDR_FLAGS && req.wdata[0]
      |=> !compare_a_flag || irq_pulse) else $error("flag a not cleared");
   irq_flag_a: assert property (
      $rose(compare_a_flag) || $rose(period_match_flag) |-> irq_pulse)
      else $error("flag set without irq");
   irq_src_a: assert property (
      irq_pulse |-> compare_a_flag || period_match_flag)
      else $error("irq without flag");
   sp_no_period_a: assert property (
      sp && $past(sp, 3) |-> !$rose(period_match_flag))
      else $error("period flag in single pulse");
   sp_pulse_end_a: assert property (
      sp && irq_pulse && !ctl[2] |-> ##[0:2] !timer_out)
      else $error("pulse not ended by match");
   cap_no_out_a: assert property (
      cap && $past(cap, 2) |-> $stable(timer_out))
      else $error("output moved in capture");
   cap_off_a: assert property (
      cap_off && $past(cap_off, 6) |-> !$rose(compare_a_flag))
      else $error("capture while disabled");
   cover property (sp && irq_pulse);
   cover property (cap && $rose(compare_a_flag));
   cover property (cap && $rose(period_match_flag));
endmodule

bind periodic_timer periodic_timer_assertions u_periodic_timer_assertions (
   .clk(clk),
   .reset(reset),
   .req(req),
   .rdata(rdata),
   .ext_clock_pin(ext_clock_pin),
   .capture_input_pin(capture_input_pin),
   .timer_out(timer_out),
   .compare_a_flag(compare_a_flag),
   .period_match_flag(period_match_flag),
   .irq_pulse(irq_pulse)
);

// ---- tb/pin_source.sv ----
// model of the external trigger and capture pins
module pin_source (
   input wire logic clk,
   output logic ext_clock_pin,
   output logic capture_input_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ext_clock_pin = 1'b0;
      capture_input_pin = 1'b0;
   end
   // sel 1 drives the ext clock pin, 0 the capture pin
   task automatic set_pin(input logic sel, input logic lvl);
      @(posedge clk);
      if (sel) begin
         ext_clock_pin <= lvl;
      end else begin
         capture_input_pin <= lvl;
      end
   endtask
endmodule

// ---- tb/tb.sv ----
// testbench for the periodic timer
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic reset;
   periodic_timer_pkg::reg_req_t req;
   logic [7:0] rdata;
   logic ext_clock_pin;
   logic capture_input_pin;
   logic timer_out;
   logic compare_a_flag;
   logic period_match_flag;
   logic irq_pulse;
   int n_errors;
   int checks;
   logic [7:0] rd_v;
   logic [7:0] c;

   periodic_timer u_periodic_timer (.clk(clk), .reset(reset), .req(req),
      .rdata(rdata), .ext_clock_pin(ext_clock_pin),
      .capture_input_pin(capture_input_pin), .timer_out(timer_out),
      .compare_a_flag(compare_a_flag),
      .period_match_flag(period_match_flag), .irq_pulse(irq_pulse));
   pin_source u_pin_source (.clk(clk), .ext_clock_pin(ext_clock_pin),
      .capture_input_pin(capture_input_pin));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      rd_v = rdata;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wait_a();
      int i;
      i = 0;
      while (compare_a_flag !== 1'b1 && i < 2000) begin
         cycles(1);
         i++;
      end
      if (i == 2000) begin
         n_errors++;
         complete_run();
      end
   endtask

   task automatic t_reset_values();
      for (int a = 0; a < 10; a++) begin
         rd(4'(a));
         chk(10'(rd_v), 10'h000);
      end
      $display("test reset_values done");
   endtask

   task automatic t_readback();
      wr(4'h5, 8'hFF);
      rd(4'h5);
      chk(10'(rd_v), 10'h003);
      wr(4'h6, 8'h5A);
      rd(4'h6);
      chk(10'(rd_v), 10'h05A);
      wr(4'h2, 8'h55);
      rd(4'h2);
      chk(10'(rd_v), 10'h000);
      wr(4'h5, 8'h00);
      $display("test readback done");
   endtask

   task automatic t_pwm();
      wr(4'h1, 8'h81);
      wr(4'h4, 8'h05);
      wr(4'h6, 8'h0C);
      wr(4'h8, 8'h03);
      wr(4'h0, 8'h08);
      cycles(40);
      chk(10'({compare_a_flag, period_match_flag}), 10'h003);
      rd(4'h2);
      chk(10'(rd_v <= 8'h0C), 10'h001);
      wr(4'h0, 8'h00);
      $display("test pwm done");
   endtask

   task automatic t_single_pulse();
      wr(4'h1, 8'hB1);
      wr(4'h6, 8'h03);
      wr(4'h4, 8'h0A);
      wr(4'h8, 8'h03);
      wr(4'h0, 8'h08);
      cycles(3);
      chk(10'(timer_out), 10'h001);
      wait_a();
      cycles(3);
      chk(10'(timer_out), 10'h000);
      chk(10'(period_match_flag), 10'h000);
      rd(4'h0);
      chk(10'(rd_v), 10'h000);
      rd(4'h2);
      chk(10'(rd_v), 10'h00A);
      cycles(5);
      rd(4'h2);
      chk(10'(rd_v), 10'h00A);
      wr(4'h8, 8'h03);
      u_pin_source.set_pin(1'b1, 1'b1);
      cycles(6);
      chk(10'(timer_out), 10'h001);
      wait_a();
      rd(4'h2);
      chk(10'(rd_v), 10'h00A);
      u_pin_source.set_pin(1'b1, 1'b0);
      $display("test single_pulse done");
   endtask

   task automatic t_capture();
      logic [3:0] rise_exp;
      logic [3:0] fall_exp;
      rise_exp = 4'h5;
      fall_exp = 4'h6;
      wr(4'h1, 8'h4C);
      wr(4'h6, 8'h00);
      wr(4'h8, 8'h03);
      wr(4'h0, 8'h08);
      rd(4'h2);
      c = rd_v;
      u_pin_source.set_pin(1'b0, 1'b1);
      cycles(8);
      chk(10'(compare_a_flag), 10'h001);
      rd(4'h4);
      chk(10'(rd_v > c && rd_v < c + 8'h10), 10'h001);
      u_pin_source.set_pin(1'b0, 1'b0);
      for (int s = 0; s < 2; s++) begin
         for (int k = 0; k < 4; k++) begin
            wr(4'h1, {2'b01, 2'(k), 2'b00, 1'(s), 1'b0});
            wr(4'h8, 8'h03);
            u_pin_source.set_pin(1'(s), 1'b1);
            cycles(8);
            chk(10'(compare_a_flag),
               10'(rise_exp[k]));
            wr(4'h8, 8'h03);
            u_pin_source.set_pin(1'(s), 1'b0);
            cycles(8);
            chk(10'(compare_a_flag), 10'(fall_exp[k]));
         end
      end
      wr(4'h0, 8'h00);
      rd(4'h2);
      c = rd_v;
      rd(4'h2);
      chk(10'(rd_v), 10'(c));
      wr(4'h6, 8'h14);
      wr(4'h0, 8'h08);
      wr(4'h8, 8'h03);
      cycles(30);
      chk(10'(period_match_flag), 10'h001);
      rd(4'h2);
      chk(10'(rd_v <= 8'h14), 10'h001);
      wr(4'h6, 8'h00);
      wr(4'h8, 8'h03);
      cycles(900);
      chk(10'(period_match_flag), 10'h000);
      cycles(200);
      chk(10'(period_match_flag), 10'h001);
      $display("test capture done");
   endtask

   initial begin
      req = '{addr: 4'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      reset = 1'b1;
      n_errors = 0;
      checks = 0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset_values();
      t_readback();
      t_pwm();
      t_single_pulse();
      t_capture();
      complete_run();
   end
endmodule
